/* File: quad_dac_pkg.sv */
// constants for the quad converter update and power-down control
// assumes a 100 MHz system clock and a 16-bit serial frame
package quad_dac_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int CH_HI_POS = 15;
  localparam int CH_LO_POS = 14;
  localparam int PM_POS = 13;
  localparam int LD_POS = 12;
  localparam int CODE_MSB = 11;
  localparam int CODE_W = 12;
  localparam int NUM_CH = 4;
  // resolution mask: all 12 bits used here, a 10-bit part would keep 12'hffc
  localparam logic [CODE_W-1:0] CODE_MASK = 12'hfff;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  localparam logic [NUM_CH-1:0] CHG_RST = 4'h0;
  localparam logic [NUM_CH-1:0] DRIVE_ALL = 4'hf;
  localparam logic [NUM_CH-1:0] DRIVE_NONE = 4'h0;
  localparam logic [4:0] CNT_RST = 5'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 10;
  localparam int EXIT_NS = 5000;
  localparam int EXIT_CYC = (EXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_W = 10;
  localparam logic [WAKE_W-1:0] WAKE_RST = 10'h000;
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(EXIT_CYC - 1);

  // ****************************************
  // power states
  // ****************************************
  typedef enum logic [2:0] {
    PWR_ON = 3'b001,
    PWR_DOWN = 3'b010,
    PWR_WAKE = 3'b100
  } pwr_t;

endpackage

/* File: quad_dac_ctl.sv */
// update and power-down control of a quad voltage-output converter
// assumes sclk/sync_n/din from a host serial controller; mclk and rst local
//
// Functional notes
// - load-all flag 1: only addressed input register written, output registers held
// - load-all flag 0: all output registers updated together at frame end
// - load-all copies a channel only if its input changed since last load
// - power mode bit 13 at 0 powers down all four channels
// - power mode bit at 1 returns all channels to normal operation
// - powered-down outputs are disconnected, drive enables low
// - power transitions leave input and output registers untouched
// - output starts moving about 5 us after the 16th falling edge
// - 16-bit frames, msb first, on falling sclk while select is low
// - bits 15:14 pick channel A..D, bit 13 power mode, bit 12 load-all
// - select rising before the 16th falling edge discards the frame
// - code left-aligned below control bits, unused lsbs ignored
`timescale 1ns/100ps
// ****************************************
// one channel: input register, output register, changed flag
// ****************************************
module quad_dac_chan (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic upd_en,
  input wire logic [11:0] code_in,
  output logic [11:0] code_q
);

  logic [11:0] in_q;
  logic [11:0] in_d;
  logic [11:0] code_d;
  logic chg_q;
  logic chg_d;

  // set wins: a channel written by an updating frame is loaded by it too
  always_comb begin
    in_d = in_q;
    code_d = code_q;
    chg_d = chg_q;
    if (wr_en) begin
      in_d = code_in;
      chg_d = 1'b1;
    end
    if (upd_en && chg_d) begin
      code_d = in_d;
      chg_d = 1'b0;
    end
  end

  // power state never reaches these registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_q <= quad_dac_pkg::CODE_RST;
      code_q <= quad_dac_pkg::CODE_RST;
      chg_q <= quad_dac_pkg::CHG_RST[0];
    end else begin
      in_q <= in_d;
      code_q <= code_d;
      chg_q <= chg_d;
    end
  end

endmodule // quad_dac_chan

module quad_dac_ctl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic [11:0] code_a_q,
  output logic [11:0] code_b_q,
  output logic [11:0] code_c_q,
  output logic [11:0] code_d_q,
  output logic [3:0] drive_en_q,
  output logic power_down_q
);

  // ****************************************
  // link domain: shift path on falling sclk
  // ****************************************
  logic [4:0] bit_cnt_q;
  logic [4:0] bit_cnt_d;
  logic done_q;
  logic done_d;
  logic [15:0] shift_q;
  logic [15:0] shift_d;

  // extra edges after the 16th are ignored; select high restarts the frame
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    done_d = done_q;
    shift_d = shift_q;
    if (!sync_n && bit_cnt_q != quad_dac_pkg::FRAME_BITS) begin
      shift_d = {shift_q[14:0], din};
      bit_cnt_d = bit_cnt_q + 5'h01;
      if (bit_cnt_q == quad_dac_pkg::FRAME_BITS - 5'h01) begin
        done_d = 1'b1;
      end
    end
  end

  // select high clears the count: a short frame never raises done
  always_ff @(negedge sclk or posedge sync_n) begin
    if (sync_n) begin
      bit_cnt_q <= quad_dac_pkg::CNT_RST;
      done_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      done_q <= done_d;
    end
  end

  // data only; frozen after the 16th edge, so mclk may read it at leisure
  always_ff @(negedge sclk) begin
    shift_q <= shift_d;
  end

  // ****************************************
  // crossing into mclk
  // ****************************************
  logic done_s1_q;
  logic done_s2_q;
  logic done_s3_q;
  logic [2:0] done_sync_d;
  logic frame_evt;

  always_comb begin
    done_sync_d = {done_s2_q, done_s1_q, done_q};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= done_sync_d[0];
      done_s2_q <= done_sync_d[1];
      done_s3_q <= done_sync_d[2];
    end
  end

  // ****************************************
  // frame word capture in mclk
  // ****************************************
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic evt_q;
  logic evt_d;

  // limitation: host holds select low at least 3 mclk after the 16th edge,
  // or the done pulse is cleared before the synchroniser sees it
  always_comb begin
    evt_d = done_s2_q & ~done_s3_q;
    word_d = word_q;
    if (evt_d) begin
      word_d = shift_q;
    end
  end

  // word is data only: no reset, read only while evt_q is high
  always_ff @(posedge mclk) begin
    word_q <= word_d;
    if (rst) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= evt_d;
    end
  end

  assign frame_evt = evt_q;

  // ****************************************
  // frame decode
  // ****************************************
  logic [1:0] f_ch;
  logic f_pm;
  logic f_ld;
  logic [11:0] f_code;

  always_comb begin
    f_ch = {word_q[quad_dac_pkg::CH_HI_POS], word_q[quad_dac_pkg::CH_LO_POS]};
    f_pm = word_q[quad_dac_pkg::PM_POS];
    f_ld = word_q[quad_dac_pkg::LD_POS];
    f_code = word_q[quad_dac_pkg::CODE_MSB:0] & quad_dac_pkg::CODE_MASK;
  end

  // ****************************************
  // double-buffered code registers
  // ****************************************
  logic [3:0] wr_en;
  logic upd_en;

  // a frame writes one input register; load-all 0 updates every changed channel
  always_comb begin
    upd_en = frame_evt && !f_ld;
    for (int i = 0; i < quad_dac_pkg::NUM_CH; i++) begin
      wr_en[i] = frame_evt && (f_ch == 2'(i));
    end
  end

  // one instance per channel, A to D in address order
  quad_dac_chan chan_a (
    .mclk(mclk),
    .rst(rst),
    .wr_en(wr_en[0]),
    .upd_en(upd_en),
    .code_in(f_code),
    .code_q(code_a_q)
  );

  quad_dac_chan chan_b (
    .mclk(mclk),
    .rst(rst),
    .wr_en(wr_en[1]),
    .upd_en(upd_en),
    .code_in(f_code),
    .code_q(code_b_q)
  );

  quad_dac_chan chan_c (
    .mclk(mclk),
    .rst(rst),
    .wr_en(wr_en[2]),
    .upd_en(upd_en),
    .code_in(f_code),
    .code_q(code_c_q)
  );

  quad_dac_chan chan_d (
    .mclk(mclk),
    .rst(rst),
    .wr_en(wr_en[3]),
    .upd_en(upd_en),
    .code_in(f_code),
    .code_q(code_d_q)
  );

  // ****************************************
  // power mode and wake-up delay
  // ****************************************
  quad_dac_pkg::pwr_t pwr_q;
  quad_dac_pkg::pwr_t pwr_d;
  logic [9:0] wake_q;
  logic [9:0] wake_d;
  logic [3:0] drive_en_d;
  logic power_down_d;

  // delay counted from the synchronised frame end, a few mclk late
  always_comb begin
    pwr_d = pwr_q;
    wake_d = wake_q;
    unique case (pwr_q)
      quad_dac_pkg::PWR_ON: begin
        if (frame_evt && !f_pm) begin
          pwr_d = quad_dac_pkg::PWR_DOWN;
        end
      end
      quad_dac_pkg::PWR_DOWN: begin
        if (frame_evt && f_pm) begin
          pwr_d = quad_dac_pkg::PWR_WAKE;
          wake_d = quad_dac_pkg::WAKE_RST;
        end
      end
      quad_dac_pkg::PWR_WAKE: begin
        if (frame_evt && !f_pm) begin
          pwr_d = quad_dac_pkg::PWR_DOWN;
        end else if (wake_q == quad_dac_pkg::WAKE_LAST) begin
          pwr_d = quad_dac_pkg::PWR_ON;
        end else begin
          wake_d = wake_q + 10'h001;
        end
      end
      default: begin
        pwr_d = quad_dac_pkg::PWR_ON;
      end
    endcase
    drive_en_d = (pwr_d == quad_dac_pkg::PWR_ON) ?
      quad_dac_pkg::DRIVE_ALL : quad_dac_pkg::DRIVE_NONE;
    power_down_d = (pwr_d == quad_dac_pkg::PWR_DOWN);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr_q <= quad_dac_pkg::PWR_ON;
      wake_q <= quad_dac_pkg::WAKE_RST;
      drive_en_q <= quad_dac_pkg::DRIVE_ALL;
      power_down_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      wake_q <= wake_d;
      drive_en_q <= drive_en_d;
      power_down_q <= power_down_d;
    end
  end

endmodule // quad_dac_ctl

/* File: quad_dac_ctl_asserts.sv */
// checker: output relations of the converter control
// assumes bind onto quad_dac_ctl, mclk domain only
`timescale 1ns/100ps
module quad_dac_ctl_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sync_n,
  input wire logic [11:0] code_a_q,
  input wire logic [11:0] code_b_q,
  input wire logic [11:0] code_c_q,
  input wire logic [11:0] code_d_q,
  input wire logic [3:0] drive_en_q,
  input wire logic power_down_q
);
  // ****
  // wake counter
  // ****
  localparam int WMIN = 495;
  localparam int WMAX = 505;
  logic [9:0] wake_q;
  logic [9:0] wake_d;
  logic [47:0] codes;
  assign codes = {code_a_q, code_b_q, code_c_q, code_d_q};
  always_comb begin
    wake_d = (rst || power_down_q || drive_en_q != 4'h0) ? 10'h000 : wake_q + 10'h001;
  end
  always_ff @(posedge mclk) begin
    wake_q <= wake_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  rst_vals_a: assert property (disable iff (1'b0) rst |=> codes == 48'h0 &&
    drive_en_q == 4'hf && !power_down_q) else $error("reset values wrong");
  en_even_a: assert property (drive_en_q == 4'h0 || drive_en_q == 4'hf)
    else $error("enables differ");
  down_off_a: assert property (power_down_q |-> drive_en_q == 4'h0)
    else $error("driving while down");
  wake_hold_a: assert property ($fell(power_down_q) |-> (drive_en_q == 4'h0) [*8])
    else $error("woke too early");
  wake_time_a: assert property ($rose(drive_en_q[0]) |-> wake_q inside {[WMIN:WMAX]})
    else $error("wake delay off");
  idle_codes_a: assert property (sync_n [*6] |-> $stable(codes))
    else $error("codes moved while idle");
  idle_mode_a: assert property (sync_n [*6] |-> $stable(power_down_q))
    else $error("mode moved while idle");
  down_mode_a: assert property ($rose(power_down_q) |-> $stable(drive_en_q) ||
    $fell(drive_en_q[0])) else $error("down entry odd");
  cover property ($rose(power_down_q));
  cover property ($rose(drive_en_q[0]));
  cover property ($changed(code_d_q));
endmodule // quad_dac_ctl_asserts
bind quad_dac_ctl quad_dac_ctl_asserts quad_dac_ctl_asserts_inst (.mclk(mclk), .rst(rst),
  .sync_n(sync_n), .code_a_q(code_a_q), .code_b_q(code_b_q), .code_c_q(code_c_q),
  .code_d_q(code_d_q), .drive_en_q(drive_en_q), .power_down_q(power_down_q));

/* File: host_ser_model.sv */
// host serial controller model, one device selected
// assumes the bench calls send; sclk still between frames
`timescale 1ns/100ps
module host_ser_model (
  output logic sclk,
  output logic sync_n,
  output logic din
);
  initial begin
    sclk = 1'b1;
    din = 1'b0;
    // a rising select clears the link counter before the first frame
    sync_n = 1'b0;
    #1 sync_n = 1'b1;
  end
  task automatic send(input logic [15:0] f, input int n);
    sync_n = 1'b0;
    #37;
    for (int i = 15; i > 15 - n; i--) begin
      din = f[i];
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
    end
    #40 sync_n = 1'b1;
    din = ~din; // data line flipped after the frame, not held
    #200;
  endtask
endmodule // host_ser_model

/* File: quad_dac_ctl_bench.sv */
// self-checking bench for the converter control
// assumes host_ser_model on the link and the bound checker
`timescale 1ns/100ps
module quad_dac_ctl_bench;
  logic mclk, rst, sclk, sync_n, din, pd_x, power_down_q;
  logic [11:0] code_a_q, code_b_q, code_c_q, code_d_q;
  logic [3:0] drive_en_q, chg, en_x;
  logic [11:0] in_r [4];
  logic [11:0] dac_r [4];
  logic [52:0] exp_q [$];
  event chk_ev;
  int failures, checked;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  quad_dac_ctl quad_dac_ctl_inst (.mclk(mclk), .rst(rst), .sclk(sclk), .sync_n(sync_n),
    .din(din), .code_a_q(code_a_q), .code_b_q(code_b_q), .code_c_q(code_c_q),
    .code_d_q(code_d_q), .drive_en_q(drive_en_q), .power_down_q(power_down_q));
  host_ser_model host_ser_model_inst (.sclk(sclk), .sync_n(sync_n), .din(din));
  // ****
  // tasks
  // ****
  task automatic give_verdict;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic note;
    exp_q.push_back({dac_r[0], dac_r[1], dac_r[2], dac_r[3], en_x, pd_x});
    -> chk_ev;
  endtask
  task automatic frame(input logic [1:0] ch, input logic pm, input logic ld,
    input logic [11:0] c, input int n);
    host_ser_model_inst.send({ch, pm, ld, c}, n);
    if (n == 16) begin
      in_r[ch] = c & quad_dac_pkg::CODE_MASK;
      chg[ch] = 1'b1;
      if (!ld) begin
        for (int i = 0; i < 4; i++) if (chg[i]) dac_r[i] = in_r[i];
        chg = 4'h0;
      end
      pd_x = !pm;
      if (!pm) en_x = 4'h0;
    end
    repeat (9) @(negedge mclk);
    note();
  endtask
  // outputs compared oldest note first
  initial begin
    forever begin
      @(chk_ev);
      checked++;
      if ({code_a_q, code_b_q, code_c_q, code_d_q, drive_en_q, power_down_q}
        !== exp_q.pop_front()) begin
        failures++;
        $display("[ERR] %0t outputs differ", $time);
      end
    end
  end
  initial begin
    rst = 1'b1;
    failures = 0;
    checked = 0;
    chg = 4'h0;
    en_x = 4'hf;
    pd_x = 1'b0;
    for (int i = 0; i < 4; i++) dac_r[i] = 12'h000;
    in_r = dac_r;
    void'($urandom(38713));
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    note();
    for (int i = 0; i < 4; i++) frame(i[1:0], 1'b1, i != 3, 12'($urandom), 16);
    frame(2'h1, 1'b1, 1'b0, 12'h5a5, 10);
    frame(2'h2, 1'b0, 1'b1, 12'h3c3, 16);
    frame(2'h0, 1'b1, 1'b0, 12'h000, 16);
    repeat (520) @(negedge mclk);
    en_x = 4'hf;
    note();
    repeat (6) frame(2'($urandom), 1'b1, 1'($urandom), 12'($urandom), 16);
    give_verdict();
  end
  // watchdog well past the roughly 26 us of traffic
  initial begin
    #300000;
    failures++;
    give_verdict();
  end
endmodule // quad_dac_ctl_bench
